// File: rtl/chip_ctl_pkg.sv
// Constants and carrier types for the chip and arbitration control dword
package chip_ctl_pkg;
    localparam logic [7:0]  CTL_DWORD_OFFSET = 8'h44;
    localparam int          BIT_WR_DISC      = 1;
    localparam int          BIT_PF_DIS       = 4;
    localparam int          BIT_CHIP_RST     = 8;
    localparam int          ARB_GRP_LSB      = 16;
    localparam int          BIT_SEC_PRIO     = 25;
    localparam logic [31:0] CTL_RW_MASK      = 32'h020f_0012;
    localparam logic [31:0] CTL_RESET_VAL    = 32'h0200_0000;
    localparam int          N_REQ            = 4;
    localparam int          RST_CYCLES_DEF   = 8;
    localparam logic [11:0] PAGE_4K_MASK     = 12'hffc;
    localparam logic [3:0]  CMD_MEM_RD       = 4'h6;

    // Configuration access from the primary side
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef enum logic [1:0] {
        CR_IDLE = 2'b00,
        CR_BUSY = 2'b01
    } crst_state_t;

    typedef struct packed {
        logic [31:0] ctl;
        logic        sec_rst;
        crst_state_t st;
        logic [7:0]  cnt;
        logic [31:0] rdata;
    } ctl_state_t;
endpackage

// File: rtl/chip_diag_arb_ctl.sv
// Chip control / diagnostic and secondary arbitration group dword
// Functional notes
// - Unused bits read zero; writes to them do nothing.
// - Write-disconnect clear: disconnect writes only on queue full or 4KB boundary.
// - Write-disconnect set: also disconnect at each cache line boundary.
// - Prefetch enabled: prefetch upstream reads, do not forward byte enables.
// - Prefetch disabled: plain read fetches one Dword, forwards byte enables.
// - Prefetch disabled: plain read disconnected on first data phase.
// - Read line and read multiple stay prefetchable regardless.
// - Writing one to chip reset resets buffers, config registers, both interfaces.
// - Chip reset bit clears itself when internal reset completes.
// - Chip reset drives secondary reset and sets bridge-control secondary-reset bit.
// - Secondary reset stays active until software clears that bit.
// - Bits 16..19 put request inputs 0..3 in high group when one.
// - Bit 25 puts bridge's own master in high group; resets to one.
// - Secondary-reset bit asserts secondary reset, initialises buffers and secondary side.
`default_nettype none
module chip_diag_arb_ctl
    import chip_ctl_pkg::*;
#(
    parameter int RST_CYCLES = RST_CYCLES_DEF
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire cfg_req_t          cfg,
    output logic [31:0]            cfg_rdata,
    input  wire logic              brctl_sec_rst_wr,
    input  wire logic              brctl_sec_rst_wdata,
    output logic                   brctl_sec_rst,
    input  wire logic              tw_valid,
    input  wire logic [11:0]       tw_addr,
    input  wire logic              tw_queue_full,
    input  wire logic [11:0]       cache_line_mask,
    output logic                   tw_disconnect,
    input  wire logic [3:0]        us_rd_cmd,
    input  wire logic [3:0]        us_rd_be,
    output logic                   us_prefetch,
    output logic                   us_fwd_be,
    output logic [3:0]             us_be_out,
    output logic                   us_single_dword,
    output logic                   us_disc_first,
    output logic                   chip_rst_req,
    output logic                   sec_buf_rst,
    output logic                   sec_rst_out_n,
    output logic [N_REQ-1:0]       req_high_grp,
    output logic                   own_high_grp
);
    ctl_state_t s_r;
    ctl_state_t s_nxt;
    logic [31:0] wmask;
    logic        hit;
    logic        plain_rd;

    // Byte-lane mask from active enables
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{cfg.be[i]}};
        end
    end

    assign hit = (cfg.addr == CTL_DWORD_OFFSET);

    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = 32'h0000_0000;
        if (cfg.rd && hit) begin
            s_nxt.rdata = s_r.ctl & CTL_RW_MASK;
            s_nxt.rdata[BIT_CHIP_RST] = (s_r.st == CR_BUSY);
        end
        if (cfg.wr && hit && s_r.st == CR_IDLE) begin
            s_nxt.ctl = (s_r.ctl & ~(wmask & CTL_RW_MASK))
                      | (cfg.wdata & wmask & CTL_RW_MASK);
            // Chip reset only when its own byte lane is enabled
            if (cfg.be[BIT_CHIP_RST / 8] && cfg.wdata[BIT_CHIP_RST]) begin
                s_nxt.st      = CR_BUSY;
                s_nxt.cnt     = 8'(RST_CYCLES);
                s_nxt.sec_rst = 1'b1;
            end
        end
        if (brctl_sec_rst_wr && s_r.st == CR_IDLE) begin
            s_nxt.sec_rst = brctl_sec_rst_wdata;
        end
        if (s_r.st == CR_BUSY) begin
            // Config registers held at reset values during chip reset
            s_nxt.ctl     = CTL_RESET_VAL;
            s_nxt.sec_rst = 1'b1;
            if (s_r.cnt == 8'h00) begin
                s_nxt.st = CR_IDLE;
            end else begin
                s_nxt.cnt = s_r.cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_r.ctl     <= CTL_RESET_VAL;
            s_r.sec_rst <= 1'b0;
            s_r.st      <= CR_IDLE;
            s_r.cnt     <= 8'h00;
            s_r.rdata   <= 32'h0000_0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cfg_rdata     = s_r.rdata;
    assign brctl_sec_rst = s_r.sec_rst;
    assign chip_rst_req  = (s_r.st == CR_BUSY);
    assign sec_rst_out_n = ~s_r.sec_rst;
    assign sec_buf_rst   = s_r.sec_rst;

    // Target write disconnect decision
    always_comb begin
        tw_disconnect = 1'b0;
        if (tw_valid) begin
            tw_disconnect = tw_queue_full || ((tw_addr & PAGE_4K_MASK) == PAGE_4K_MASK);
            if (s_r.ctl[BIT_WR_DISC] && ((tw_addr & cache_line_mask) == cache_line_mask)) begin
                tw_disconnect = 1'b1;
            end
        end
    end

    // Only plain memory read is affected; line and multiple always prefetch
    assign plain_rd        = (us_rd_cmd == CMD_MEM_RD);
    assign us_single_dword = plain_rd && s_r.ctl[BIT_PF_DIS];
    assign us_prefetch     = !us_single_dword;
    assign us_fwd_be       = us_single_dword;
    assign us_be_out       = us_single_dword ? us_rd_be : 4'h0;
    assign us_disc_first   = us_single_dword;

    genvar g;
    generate
        for (g = 0; g < N_REQ; g++) begin : g_grp
            assign req_high_grp[g] = s_r.ctl[ARB_GRP_LSB + g];
        end
    endgenerate
    assign own_high_grp = s_r.ctl[BIT_SEC_PRIO];
endmodule
`default_nettype wire

// File: sim/cfg_host.sv
// Host model issuing configuration accesses
`default_nettype none
module cfg_host
    import chip_ctl_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic [31:0] cfg_rdata,
    output cfg_req_t         cfg
);
    timeunit 1ns;
    timeprecision 1ns;
    initial cfg = '0;
    task automatic wr(input logic [3:0] be, input logic [31:0] d);
        @(negedge ref_clk) cfg <= '{1'b0, 1'b1, 8'h44, be, d};
        @(negedge ref_clk) cfg <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(negedge ref_clk) cfg <= '{1'b1, 1'b0, a, 4'hf, 32'h0};
        @(negedge ref_clk) cfg <= '0;
        q = cfg_rdata;
    endtask
endmodule
`default_nettype wire

// File: sim/chip_diag_arb_ctl_chk.sv
// Assertions for the chip and arbitration control dword
`default_nettype none
module chip_diag_arb_ctl_chk
    import chip_ctl_pkg::*;
#(parameter int RST_CYCLES = RST_CYCLES_DEF) (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire cfg_req_t    cfg,
    input wire logic [31:0] cfg_rdata,
    input wire logic        brctl_sec_rst,
    input wire logic        chip_rst_req,
    input wire logic        sec_rst_out_n,
    input wire logic [3:0]  req_high_grp,
    input wire logic        own_high_grp,
    input wire logic [3:0]  us_rd_cmd,
    input wire logic        us_prefetch,
    input wire logic        tw_valid,
    input wire logic        tw_queue_full,
    input wire logic        tw_disconnect
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr; cfg.wr && cfg.addr == 8'h44 && !chip_rst_req && !(cfg.be[1] && cfg.wdata[8]); endsequence
    sequence s_crst; cfg.wr && cfg.addr == 8'h44 && cfg.be[1] && cfg.wdata[8] && !chip_rst_req; endsequence
    property p_grp; s_wr ##0 cfg.be[2] |=> req_high_grp == $past(cfg.wdata[19:16]); endproperty
    property p_own; s_wr ##0 cfg.be[3] |=> own_high_grp == $past(cfg.wdata[25]); endproperty
    property p_rsv; (cfg_rdata & 32'hfdf0_feed) == 32'h0; endproperty
    property p_crst; s_crst |=> chip_rst_req && !sec_rst_out_n && brctl_sec_rst; endproperty
    property p_clr; $rose(chip_rst_req) |-> ##RST_CYCLES chip_rst_req ##1 !chip_rst_req; endproperty
    property p_sec; sec_rst_out_n == !brctl_sec_rst; endproperty
    property p_pf; us_rd_cmd inside {4'hc, 4'he} |-> us_prefetch; endproperty
    property p_qf; tw_valid && tw_queue_full |-> tw_disconnect; endproperty
    a_grp: assert property (p_grp) else $error("group bits not written");
    a_own: assert property (p_own) else $error("own priority not written");
    a_rsv: assert property (p_rsv) else $error("unused bit reads one");
    a_crst: assert property (p_crst) else $error("chip reset not started");
    a_clr: assert property (p_clr) else $error("chip reset length wrong");
    a_sec: assert property (p_sec) else $error("secondary reset mismatch");
    a_pf: assert property (p_pf) else $error("line read not prefetched");
    a_qf: assert property (p_qf) else $error("no disconnect on full");
endmodule
bind chip_diag_arb_ctl chip_diag_arb_ctl_chk #(.RST_CYCLES(RST_CYCLES)) chk (.*);
`default_nettype wire

// File: sim/chip_diag_arb_ctl_tb.sv
// Testbench for the chip and arbitration control dword
`default_nettype none
module chip_diag_arb_ctl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, rst_n = 0, brctl_sec_rst_wr = 0, brctl_sec_rst_wdata = 0, tw_valid = 1, tw_queue_full = 0;
    logic [11:0] tw_addr = 12'h03c, cache_line_mask = 12'h03c;
    logic [3:0]  us_rd_cmd = 4'h6, us_rd_be = 4'h5, us_be_out, req_high_grp;
    logic [31:0] cfg_rdata, q;
    logic brctl_sec_rst, tw_disconnect, us_prefetch, us_fwd_be, us_single_dword, us_disc_first;
    logic chip_rst_req, sec_buf_rst, sec_rst_out_n, own_high_grp;
    chip_ctl_pkg::cfg_req_t cfg;
    int errors = 0, samples_checked = 0;
    always #10 ref_clk = ~ref_clk;
    chip_diag_arb_ctl #(.RST_CYCLES(4)) dut (.*);
    cfg_host host (.ref_clk, .cfg_rdata, .cfg);
    task automatic chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #20us;
        errors++;
        finish_test;
    end
    initial begin
        repeat (8) @(negedge ref_clk);
        rst_n = 1;
        host.rd(8'h44, q);
        chk(q, 32'h0200_0000);
        host.wr(4'hd, 32'hffff_ffff);
        host.rd(8'h44, q);
        chk(q, 32'h020f_0012);
        chk(32'({req_high_grp, own_high_grp}), 32'h1f);
        host.rd(8'h48, q);
        chk(q, 32'h0);
        chk(32'({us_prefetch, us_single_dword, us_disc_first, us_fwd_be, us_be_out}), 32'h75);
        chk(32'(tw_disconnect), 32'h1);
        us_rd_cmd = 4'hc;
        #1 chk(32'(us_prefetch), 32'h1);
        host.wr(4'h1, 32'h0);
        us_rd_cmd = 4'h6;
        #1 chk(32'({us_prefetch, us_fwd_be, tw_disconnect}), 32'h4);
        tw_addr = 12'hffc;
        #1 chk(32'(tw_disconnect), 32'h1);
        tw_addr = 12'h03c;
        tw_queue_full = 1;
        #1 chk(32'(tw_disconnect), 32'h1);
        host.wr(4'h2, 32'h100);
        chk(32'({chip_rst_req, sec_rst_out_n, brctl_sec_rst}), 32'h5);
        repeat (6) @(negedge ref_clk);
        host.rd(8'h44, q);
        chk(q, 32'h0200_0000);
        chk(32'(sec_rst_out_n), 32'h0);
        @(negedge ref_clk) brctl_sec_rst_wr = 1;
        @(negedge ref_clk) brctl_sec_rst_wr = 0;
        chk(32'({sec_rst_out_n, sec_buf_rst}), 32'h2);
        finish_test;
    end
endmodule
`default_nettype wire
